//--- include/fess_defs.vh
// Constants for the flash erase status sequencer host controller
`ifndef FESS_DEFS_VH
`define FESS_DEFS_VH

// Flash command bytes
`define FESS_CMD_READ_STATUS   8'h70
`define FESS_CMD_BLOCK_SETUP   8'h20
`define FESS_CMD_CHIP_SETUP    8'h30
`define FESS_CMD_CONFIRM       8'hD0
`define FESS_CMD_READ_ARRAY    8'hFF
`define FESS_CMD_CLEAR_STATUS  8'h50

// Status register bit positions
`define FESS_SR_READY          7
`define FESS_SR_ERASE_SUSP     6
`define FESS_SR_ERASE_ERR      5
`define FESS_SR_PROG_ERR       4
`define FESS_SR_VOLT_ERR       3
`define FESS_SR_PROG_SUSP      2
`define FESS_SR_PROTECT        1
`define FESS_SR_MASK           8'hFE

// Host register indices
`define FESS_REG_CTRL          2'h0
`define FESS_REG_ADDR          2'h1
`define FESS_REG_STAT          2'h2
`define FESS_REG_FLASH_SR      2'h3

// Control register fields
`define FESS_CTRL_GO           0
`define FESS_CTRL_CHIP         1
`define FESS_CTRL_CLEAR        2
`define FESS_CTRL_LAST         3

// Bus cycle timing, in core clocks
`define FESS_WE_CYCLES         4'h3
`define FESS_RD_CYCLES         4'h4

`endif

//--- hdl/fess_host.v
// Host controller that sequences flash block and chip erases and checks status
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "fess_defs.vh"

module fess_host #(
	parameter AW = 21
) (
	// Clock and reset
	input  wire          core_clk,
	input  wire          rst_n,
	// Software register port
	input  wire [1:0]    reg_addr,
	input  wire [31:0]   reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [31:0]   reg_rdata,
	// Flash bus
	output reg  [AW-1:0] flash_addr,
	output reg  [7:0]    flash_dq_out,
	input  wire [7:0]    flash_dq_in,
	output reg           flash_dq_oe_n,
	output reg           flash_ce_n,
	output reg           flash_we_n,
	output reg           flash_oe_n,
	input  wire          ready_busy_pin
);

////////////////////////////////////////////////////////////////////////////////
localparam S_IDLE   = 4'h0;
localparam S_STAT   = 4'h1;
localparam S_POLL0  = 4'h2;
localparam S_SETUP  = 4'h3;
localparam S_CONF   = 4'h4;
localparam S_POLL1  = 4'h5;
localparam S_CHECK  = 4'h6;
localparam S_CLEAR  = 4'h7;
localparam S_ARRAY  = 4'h8;
localparam S_WRITE  = 4'h9;
localparam S_READ   = 4'hA;

reg  [3:0]    state_ff;
reg  [3:0]    ret_ff;
reg  [3:0]    cnt_ff;
reg           chip_ff;
reg           last_ff;
reg           busy_ff;
reg           done_ff;
reg  [7:0]    sr_ff;
reg  [AW-1:0] blk_ff;
reg  [2:0]    rb_sync_ff;
reg           rb_ff;
reg  [7:0]    err_ff;

// Error summary: bit0 sequence, bit1 erase, bit2 voltage, bit3 protect
function [3:0] fess_errs;
	input [7:0] sr;
	reg   [7:0] m;
	begin
		m = sr & `FESS_SR_MASK;
		fess_errs[0] = m[`FESS_SR_ERASE_ERR] & m[`FESS_SR_PROG_ERR];
		fess_errs[1] = m[`FESS_SR_ERASE_ERR] & ~m[`FESS_SR_PROG_ERR];
		fess_errs[2] = m[`FESS_SR_VOLT_ERR];
		fess_errs[3] = m[`FESS_SR_PROTECT];
	end
endfunction

wire [3:0] errs = fess_errs(sr_ff);

// Pin filter: ready/busy level moves only once the last two stages agree
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		rb_sync_ff <= 3'h7;
		rb_ff      <= 1'b1;
	end else begin
		rb_sync_ff <= {rb_sync_ff[1:0], ready_busy_pin};
		if (rb_sync_ff[2] == rb_sync_ff[1])
			rb_ff <= rb_sync_ff[2];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Register read port
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		reg_rdata <= 32'h0000_0000;
	end else if (reg_rd) begin
		case (reg_addr)
			`FESS_REG_CTRL:     reg_rdata <= {28'h000_0000, last_ff, 1'b0, chip_ff, 1'b0};
			`FESS_REG_ADDR:     reg_rdata <= {{(32-AW){1'b0}}, blk_ff};
			`FESS_REG_STAT:     reg_rdata <= {20'h0_0000, err_ff, rb_ff,
						done_ff, busy_ff, 1'b0};
			`FESS_REG_FLASH_SR: reg_rdata <= {24'h00_0000, sr_ff & `FESS_SR_MASK};
			default:            reg_rdata <= 32'h0000_0000;
		endcase
	end else begin
		reg_rdata <= 32'h0000_0000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Erase sequencer and flash bus cycles
always @(posedge core_clk or negedge rst_n) begin
	if (!rst_n) begin
		state_ff      <= S_IDLE;
		ret_ff        <= S_IDLE;
		cnt_ff        <= 4'h0;
		chip_ff       <= 1'b0;
		last_ff       <= 1'b0;
		busy_ff       <= 1'b0;
		done_ff       <= 1'b0;
		sr_ff         <= 8'h00;
		blk_ff        <= {AW{1'b0}};
		err_ff        <= 8'h00;
		flash_addr    <= {AW{1'b0}};
		flash_dq_out  <= 8'h00;
		flash_dq_oe_n <= 1'b1;
		flash_ce_n    <= 1'b1;
		flash_we_n    <= 1'b1;
		flash_oe_n    <= 1'b1;
	end else begin
		if (reg_wr && reg_addr == `FESS_REG_ADDR && !busy_ff)
			blk_ff <= reg_wdata[AW-1:0];
		case (state_ff)
			S_IDLE: begin
				if (reg_wr && reg_addr == `FESS_REG_CTRL) begin
					chip_ff <= reg_wdata[`FESS_CTRL_CHIP];
					last_ff <= reg_wdata[`FESS_CTRL_LAST];
					if (reg_wdata[`FESS_CTRL_CLEAR]) begin
						busy_ff <= 1'b1;
						done_ff <= 1'b0;
						err_ff  <= 8'h00;
						flash_dq_out <= `FESS_CMD_CLEAR_STATUS;
						ret_ff  <= S_IDLE;
						state_ff <= S_WRITE;
					end else if (reg_wdata[`FESS_CTRL_GO]) begin
						busy_ff <= 1'b1;
						done_ff <= 1'b0;
						flash_dq_out <= `FESS_CMD_READ_STATUS;
						ret_ff  <= S_POLL0;
						state_ff <= S_WRITE;
					end
				end
			end
			S_POLL0: begin
				ret_ff <= S_POLL0;
				state_ff <= S_READ;
			end
			S_SETUP: begin
				flash_dq_out <= chip_ff ? `FESS_CMD_CHIP_SETUP : `FESS_CMD_BLOCK_SETUP;
				ret_ff   <= S_CONF;
				state_ff <= S_WRITE;
			end
			S_CONF: begin
				flash_dq_out <= `FESS_CMD_CONFIRM;
				flash_addr   <= chip_ff ? {AW{1'b0}} : blk_ff;
				ret_ff   <= S_POLL1;
				state_ff <= S_WRITE;
			end
			S_POLL1: begin
				ret_ff <= S_POLL1;
				state_ff <= S_READ;
			end
			S_CHECK: begin
				// Sticky device bits accumulate; report on each erase
				err_ff   <= {4'h0, errs};
				flash_dq_out <= `FESS_CMD_READ_ARRAY;
				ret_ff   <= S_IDLE;
				state_ff <= last_ff ? S_WRITE : S_IDLE;
				if (!last_ff) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end
			end
			S_WRITE: begin
				flash_ce_n    <= 1'b0;
				flash_we_n    <= 1'b0;
				flash_dq_oe_n <= 1'b0;
				cnt_ff   <= cnt_ff + 4'h1;
				if (cnt_ff == `FESS_WE_CYCLES) begin
					flash_ce_n    <= 1'b1;
					flash_we_n    <= 1'b1;
					flash_dq_oe_n <= 1'b1;
					cnt_ff   <= 4'h0;
					state_ff <= ret_ff;
					if (ret_ff == S_IDLE) begin
						busy_ff <= 1'b0;
						done_ff <= 1'b1;
					end
				end
			end
			S_READ: begin
				flash_ce_n <= 1'b0;
				flash_oe_n <= 1'b0;
				cnt_ff <= cnt_ff + 4'h1;
				if (cnt_ff == `FESS_RD_CYCLES) begin
					flash_ce_n <= 1'b1;
					flash_oe_n <= 1'b1;
					cnt_ff <= 4'h0;
					sr_ff  <= flash_dq_in;
					if (flash_dq_in[`FESS_SR_READY])
						state_ff <= (ret_ff == S_POLL0) ? S_SETUP : S_CHECK;
					else
						state_ff <= ret_ff;
				end
			end
			default: state_ff <= S_IDLE;
		endcase
	end
end

endmodule // fess_host

//--- sim/fess_props.sv
// Concurrent checks on the host controller's ports
`timescale 1ns/1ps
module fess_props (
	input logic        core_clk,
	input logic        rst_n,
	input logic        reg_rd,
	input logic [31:0] reg_rdata,
	input logic [7:0]  flash_dq_out,
	input logic        flash_dq_oe_n,
	input logic        flash_ce_n,
	input logic        flash_we_n,
	input logic        flash_oe_n
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// Write strobe is low for three cycles, read strobe for four
	property p_we_len; $fell(flash_we_n) |-> !flash_we_n[*3] ##1 flash_we_n; endproperty
	a_we_len: assert property (p_we_len) else $error("write pulse");
	property p_oe_len; $fell(flash_oe_n) |-> !flash_oe_n[*4] ##1 flash_oe_n; endproperty
	a_oe_len: assert property (p_oe_len) else $error("read pulse");
	property p_drive; !flash_we_n |-> !flash_dq_oe_n && !flash_ce_n && flash_oe_n; endproperty
	a_drive: assert property (p_drive) else $error("write drive");
	property p_free; !flash_oe_n |-> flash_dq_oe_n && !flash_ce_n; endproperty
	a_free: assert property (p_free) else $error("read drive");
	property p_hold; !flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out); endproperty
	a_hold: assert property (p_hold) else $error("byte moved");
	property p_cmd; $fell(flash_we_n) |-> flash_dq_out inside {8'h70, 8'h20, 8'h30, 8'hD0, 8'hFF, 8'h50}; endproperty
	a_cmd: assert property (p_cmd) else $error("bad byte");
	property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
	a_rdata: assert property (p_rdata) else $error("stray data");
	property p_idle; flash_ce_n |-> flash_we_n && flash_oe_n; endproperty
	a_idle: assert property (p_idle) else $error("strobe idle");
endmodule // fess_props
bind fess_host fess_props u_props (.core_clk(core_clk), .rst_n(rst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));

//--- sim/fess_flash_model.sv
// Behavioural flash device for erase commands and status reads
`timescale 1ns/1ps
module fess_flash_model #(
	parameter       BUSY      = 40,
	// Identifier command and lock code are arbitrary model choices
	parameter [7:0] ID_CMD    = 8'hEE,
	parameter [7:0] LOCK_CODE = 8'h00
) (
	input  logic        core_clk,
	input  logic [20:0] flash_addr,
	input  logic [7:0]  flash_dq_out,
	input  logic        flash_ce_n,
	input  logic        flash_we_n,
	input  logic        flash_oe_n,
	input  logic [7:0]  fail,
	output logic [7:0]  flash_dq_in,
	output logic        ready_busy_pin
);
	logic [7:0] sr = 8'h81, cmd = 8'h00, setup = 8'h00, last = 8'h00;
	logic we_d = 1'b1, stat = 1'b0, ident = 1'b0;
	logic [20:0] erase_addr = 21'h0;
	int cnt = 0, viol = 0, chips = 0;
	assign ready_busy_pin = cnt == 0;
	// Deselected bus shows the inverse of the last byte; identifier mode shows the lock code
	assign flash_dq_in = (flash_oe_n || flash_ce_n) ? ~last :
		((stat || cnt != 0) ? sr : (ident ? LOCK_CODE : 8'hA5));
	always @(posedge core_clk) begin
		we_d <= flash_we_n;
		if (!flash_we_n) cmd <= flash_dq_out;
		if (!flash_oe_n) last <= flash_dq_in;
		if (cnt == 1) sr <= sr | fail | 8'h80;
		if (cnt != 0) cnt <= cnt - 1;
		if (flash_we_n && !we_d && cnt == 0) begin
			setup <= (cmd == 8'h20 || cmd == 8'h30) ? cmd : 8'h00;
			stat <= cmd != 8'hFF && cmd != ID_CMD;
			ident <= cmd == ID_CMD;
			if (cmd == 8'h50) sr[5:1] <= 5'h00;
			else if ((setup != 8'h00) != (cmd == 8'hD0)) sr[5:4] <= 2'b11;
			else if (cmd == 8'hD0) begin
				cnt <= BUSY;
				sr[7] <= 1'b0;
				viol <= viol + (sr[5:1] != 5'h00);
				if (setup == 8'h30) chips <= chips + 1;
				else erase_addr <= flash_addr;
			end
		end
	end
endmodule // fess_flash_model

//--- sim/tb.sv
// Self-checking bench for the erase sequencer host controller
`timescale 1ns/1ps
`include "fess_defs.vh"
module tb;
	logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rb, dq_oe_n, ce_n, we_n, oe_n;
	logic [1:0] reg_addr = 2'h0;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, rv;
	logic [20:0] fa;
	logic [7:0] dq_o, dq_i, fail = 8'h00;
	logic [7:0] codes [4] = '{8'h20, 8'h08, 8'h02, 8'h30};
	logic [3:0] errs [4] = '{4'h2, 4'h4, 4'h8, 4'h1};
	int failures = 0, n_checks = 0, cyc = 0, i;
	fess_host u_fess_host (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_addr(fa), .flash_dq_out(dq_o),
		.flash_dq_in(dq_i), .flash_dq_oe_n(dq_oe_n), .flash_ce_n(ce_n), .flash_we_n(we_n),
		.flash_oe_n(oe_n), .ready_busy_pin(rb));
	fess_flash_model u_fess_flash_model (.core_clk(core_clk), .flash_addr(fa), .flash_dq_out(dq_o),
		.flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .fail(fail), .flash_dq_in(dq_i),
		.ready_busy_pin(rb));
	initial forever #12.5 core_clk = ~core_clk;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task automatic erase(input logic [31:0] ctrl);
		wr(`FESS_REG_CTRL, ctrl);
		rv = 32'h0000_0002;
		for (int k = 0; k < 500 && rv[1] !== 1'b0; k++) rd(`FESS_REG_STAT);
		chk(rv[2:1], 2'b10);
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			end_of_test;
		end
	end
	initial begin
		repeat (10) @(posedge core_clk);
		rst_n <= 1'b1;
		for (i = 0; i < 2; i++) begin
			wr(`FESS_REG_ADDR, 32'h0001_0000 << i);
			erase(32'h0000_0001);
			chk(u_fess_flash_model.erase_addr, 32'h0001_0000 << i);
		end
		rd(`FESS_REG_FLASH_SR);
		chk(rv, 32'h0000_0080);
		rd(`FESS_REG_STAT);
		chk(rv[7:3], 5'h01);
		erase(32'h0000_000B);
		chk(u_fess_flash_model.chips, 1);
		chk(u_fess_flash_model.stat, 1'b0);
		rd(`FESS_REG_CTRL);
		chk(rv, 32'h0000_000A);
		rd(`FESS_REG_ADDR);
		chk(rv, 32'h0002_0000);
		// Each failing erase is reported, then cleared before the next attempt
		for (i = 0; i < 4; i++) begin
			fail <= codes[i];
			erase(32'h0000_0001);
			rd(`FESS_REG_STAT);
			chk(rv[7:4], errs[i]);
			rd(`FESS_REG_FLASH_SR);
			chk(rv, {24'h00_0000, 8'h80 | codes[i]});
			erase(32'h0000_0004);
			rd(`FESS_REG_STAT);
			chk(rv[7:4], 4'h0);
		end
		chk(u_fess_flash_model.viol, 0);
		end_of_test;
	end
endmodule // tb
